// ==== touch_report_device.sv ====
// What this block does
// - Address top bits 011, then write/read bit
// - Address low bits match config bits 7:4
// - Stop ends packet; bare start restarts
// - Host waits on interrupt, then reads bus
// - Host sends start command before reading
// - Report sent as bytes, header to checksum
// - Report is always 26 bytes long
// - First two bytes are header 0xAAAA
// - Length byte holds 26 in low six
// - Count byte holds touch count, low four
// - Point one X: twelve bits, top zero
// - Point one Y follows X, same form
// - Five X/Y pairs follow in order
// - Last byte is XOR of previous 25
//
// Touch module end of the serial report link: slave address decode, start
// command, and a 26-byte report read out of a snapshot of the touch inputs.
// Assumes the host alone drives the serial clock and never stretches it.
`timescale 1ns/100ps
module touch_report_device #(
	parameter logic [7:0] START_CMD = touch_pkg::START_CMD_DEF
) (
	// Clock, reset and enable
	input wire logic MCLK_IN,
	input wire logic RESETN_IN,
	input wire logic CE_IN,
	// Serial link
	touch_i2c_if.device BUS,
	// Address configuration and touch data
	input wire logic [7:0] ADDR_CFG_IN,
	input wire logic REPORT_VALID_IN,
	input wire logic [3:0] POINT_COUNT_IN,
	input wire logic [touch_pkg::POINTS*touch_pkg::COORD_W-1:0] X_IN,
	input wire logic [touch_pkg::POINTS*touch_pkg::COORD_W-1:0] Y_IN,
	// Status
	output logic FETCHED_OUT
);
	touch_pkg::dev_state_t state_q;
	logic [7:0] shift_q;
	logic [2:0] bit_q;
	logic got_q;
	logic rw_q;
	logic sda_oe_q;
	logic int_n_q;
	logic armed_q;
	logic [4:0] idx_q;
	logic fetched_q;
	logic [3:0] snap_cnt_q;
	logic [15:0] snap_x_q [touch_pkg::POINTS];
	logic [15:0] snap_y_q [touch_pkg::POINTS];
	logic [7:0] pkt [touch_pkg::PKT_BYTES];
	logic [7:0] csum;
	logic [7:0] tx_byte;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic quiet;
	logic addr_hit;
	logic cmd_hit;
	logic byte_sent;
	logic report_take;

	// ****************************************
	// Line events
	// ****************************************
	i2c_line_watch u_watch (
		.clk_in(MCLK_IN),
		.resetn_in(RESETN_IN),
		.ce_in(CE_IN),
		.scl_in(BUS.scl),
		.sda_in(BUS.sda),
		.scl_rise_out(scl_rise),
		.scl_fall_out(scl_fall),
		.start_out(start_ev),
		.stop_out(stop_ev)
	);

	// Decoded moments of the byte engine
	assign quiet = ~start_ev & ~stop_ev;
	assign addr_hit = shift_q[7:1] == {touch_pkg::ADDR_HI,
		ADDR_CFG_IN[touch_pkg::CFG_ADDR_MSB:touch_pkg::CFG_ADDR_LSB]};
	assign cmd_hit = quiet & scl_fall & got_q & (state_q == touch_pkg::D_WRITE)
		& (shift_q == START_CMD);
	assign byte_sent = quiet & scl_fall & (state_q == touch_pkg::D_READ)
		& (bit_q == touch_pkg::BIT_LAST);
	assign report_take = REPORT_VALID_IN & ~armed_q;

	// ****************************************
	// Report assembly
	// ****************************************
	// Fixed fields, then five coordinate pairs high byte first, then checksum
	always_comb begin
		pkt[touch_pkg::IDX_HEAD0] = touch_pkg::HEAD_BYTE;
		pkt[touch_pkg::IDX_HEAD1] = touch_pkg::HEAD_BYTE;
		pkt[touch_pkg::IDX_LEN] = {2'h0, touch_pkg::PKT_LEN};
		pkt[touch_pkg::IDX_COUNT] = {4'h0, snap_cnt_q};
		pkt[touch_pkg::IDX_RSVD] = touch_pkg::RESERVED_VAL;
		for (int p = 0; p < touch_pkg::POINTS; p++) begin
			pkt[touch_pkg::IDX_COORD0 + touch_pkg::COORD_BYTES*p] = snap_x_q[p][15:8];
			pkt[touch_pkg::IDX_COORD0 + touch_pkg::COORD_BYTES*p + 1] = snap_x_q[p][7:0];
			pkt[touch_pkg::IDX_COORD0 + touch_pkg::COORD_BYTES*p + 2] = snap_y_q[p][15:8];
			pkt[touch_pkg::IDX_COORD0 + touch_pkg::COORD_BYTES*p + 3] = snap_y_q[p][7:0];
		end
		csum = 8'h00;
		for (int i = 0; i < int'(touch_pkg::IDX_CSUM); i++) begin
			csum = csum ^ pkt[i];
		end
		pkt[touch_pkg::IDX_CSUM] = csum;
	end

	// Outside an armed packet the module answers reads with zero bytes
	assign tx_byte = (armed_q && idx_q <= touch_pkg::IDX_CSUM) ? pkt[idx_q]
		: touch_pkg::RESERVED_VAL;

	// ****************************************
	// Touch snapshot
	// ****************************************
	// Frozen while a packet is being read so the checksum stays coherent
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			snap_cnt_q <= 4'h0;
			for (int p = 0; p < touch_pkg::POINTS; p++) begin
				snap_x_q[p] <= 16'h0000;
				snap_y_q[p] <= 16'h0000;
			end
		end else if (CE_IN && report_take) begin
			snap_cnt_q <= POINT_COUNT_IN;
			for (int p = 0; p < touch_pkg::POINTS; p++) begin
				snap_x_q[p] <= {{touch_pkg::COORD_PAD{1'b0}},
					X_IN[p*touch_pkg::COORD_W +: touch_pkg::COORD_W]};
				snap_y_q[p] <= {{touch_pkg::COORD_PAD{1'b0}},
					Y_IN[p*touch_pkg::COORD_W +: touch_pkg::COORD_W]};
			end
		end
	end

	// ****************************************
	// Interrupt line
	// ****************************************
	// New report pulls it low; the start command releases it, report wins
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			int_n_q <= 1'h1;
		end else if (CE_IN) begin
			if (report_take) begin
				int_n_q <= 1'h0;
			end else if (cmd_hit) begin
				int_n_q <= 1'h1;
			end
		end
	end

	// ****************************************
	// Packet pointer
	// ****************************************
	// Armed by the start command, disarmed after the checksum byte
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			armed_q <= 1'h0;
			idx_q <= 5'h00;
			fetched_q <= 1'h0;
		end else if (CE_IN) begin
			fetched_q <= 1'h0;
			if (cmd_hit) begin
				armed_q <= 1'h1;
				idx_q <= touch_pkg::IDX_HEAD0;
			end else if (byte_sent && armed_q) begin
				idx_q <= idx_q + 5'h01;
				if (idx_q == touch_pkg::IDX_CSUM) begin
					armed_q <= 1'h0;
					fetched_q <= 1'h1;
				end
			end
		end
	end

	// ****************************************
	// Byte engine
	// ****************************************
	// Samples on clock rise, drives data just after clock fall
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			state_q <= touch_pkg::D_IDLE;
			shift_q <= 8'h00;
			bit_q <= 3'h0;
			got_q <= 1'h0;
			rw_q <= 1'h0;
			sda_oe_q <= 1'h0;
		end else if (CE_IN) begin
			if (start_ev) begin
				state_q <= touch_pkg::D_ADDR;
				bit_q <= 3'h0;
				got_q <= 1'h0;
				sda_oe_q <= 1'h0;
			end else if (stop_ev) begin
				state_q <= touch_pkg::D_IDLE;
				sda_oe_q <= 1'h0;
			end else begin
				case (state_q)
					touch_pkg::D_ADDR, touch_pkg::D_WRITE: begin
						if (scl_rise) begin
							shift_q <= {shift_q[6:0], BUS.sda};
							bit_q <= bit_q + 3'h1;
							got_q <= bit_q == touch_pkg::BIT_LAST;
						end else if (scl_fall && got_q) begin
							got_q <= 1'h0;
							if (state_q == touch_pkg::D_WRITE) begin
								sda_oe_q <= 1'h1;
								state_q <= touch_pkg::D_WRITE_ACK;
							end else if (addr_hit) begin
								sda_oe_q <= 1'h1;
								rw_q <= shift_q[0] == touch_pkg::RW_READ;
								state_q <= touch_pkg::D_ADDR_ACK;
							end else begin
								state_q <= touch_pkg::D_IDLE;
							end
						end
					end
					touch_pkg::D_ADDR_ACK: begin
						if (scl_fall) begin
							bit_q <= 3'h0;
							if (rw_q) begin
								sda_oe_q <= ~tx_byte[7];
								shift_q <= {tx_byte[6:0], 1'h0};
								state_q <= touch_pkg::D_READ;
							end else begin
								sda_oe_q <= 1'h0;
								state_q <= touch_pkg::D_WRITE;
							end
						end
					end
					touch_pkg::D_WRITE_ACK: begin
						if (scl_fall) begin
							sda_oe_q <= 1'h0;
							state_q <= touch_pkg::D_WRITE;
						end
					end
					touch_pkg::D_READ: begin
						if (scl_fall) begin
							if (bit_q == touch_pkg::BIT_LAST) begin
								sda_oe_q <= 1'h0;
								state_q <= touch_pkg::D_READ_ACK;
							end else begin
								sda_oe_q <= ~shift_q[7];
								shift_q <= {shift_q[6:0], 1'h0};
								bit_q <= bit_q + 3'h1;
							end
						end
					end
					touch_pkg::D_READ_ACK: begin
						if (scl_rise && BUS.sda != touch_pkg::ACK_LOW) begin
							state_q <= touch_pkg::D_IDLE; // Host ends the read
						end else if (scl_fall) begin
							sda_oe_q <= ~tx_byte[7];
							shift_q <= {tx_byte[6:0], 1'h0};
							bit_q <= 3'h0;
							state_q <= touch_pkg::D_READ;
						end
					end
					default: begin
						state_q <= touch_pkg::D_IDLE;
						sda_oe_q <= 1'h0;
					end
				endcase
			end
		end
	end

	// Link and status outputs
	assign BUS.sda_dev_out = touch_pkg::OD_LOW;
	assign BUS.sda_dev_oe = sda_oe_q;
	assign BUS.int_n = int_n_q;
	assign FETCHED_OUT = fetched_q;
endmodule

// ==== touch_pkg.sv ====
// Shared constants for the touch report link: address, packet layout, timing.
// Assumes both ends run on one 10 MHz clock and share the open-drain link.
package touch_pkg;

	// ****************************************
	// Addressing and command
	// ****************************************
	localparam logic [2:0] ADDR_HI = 3'h3;
	localparam logic RW_WRITE = 1'h0;
	localparam logic RW_READ = 1'h1;
	localparam int CFG_ADDR_MSB = 7;
	localparam int CFG_ADDR_LSB = 4;
	// Start command value is arbitrary; both ends take it as a parameter
	localparam logic [7:0] START_CMD_DEF = 8'h00;
	localparam logic ACK_LOW = 1'h0;
	localparam logic OD_LOW = 1'h0;

	// ****************************************
	// Packet layout
	// ****************************************
	localparam int POINTS = 5;
	localparam int COORD_W = 12;
	localparam int COORD_PAD = 4;
	localparam int PKT_BYTES = 26;
	localparam logic [7:0] HEAD_BYTE = 8'haa;
	localparam logic [5:0] PKT_LEN = 6'h1a;
	localparam logic [7:0] RESERVED_VAL = 8'h00;
	localparam logic [4:0] IDX_HEAD0 = 5'h00;
	localparam logic [4:0] IDX_HEAD1 = 5'h01;
	localparam logic [4:0] IDX_LEN = 5'h02;
	localparam logic [4:0] IDX_COUNT = 5'h03;
	localparam logic [4:0] IDX_RSVD = 5'h04;
	localparam int IDX_COORD0 = 5;
	localparam int COORD_BYTES = 4;
	localparam logic [4:0] IDX_CSUM = 5'h19;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	// ****************************************
	// Host sequence steps
	// ****************************************
	localparam logic [5:0] STEP_ADDR_W = 6'h00;
	localparam logic [5:0] STEP_CMD = 6'h01;
	localparam logic [5:0] STEP_RESTART = 6'h02;
	localparam logic [5:0] STEP_ADDR_R = 6'h03;
	localparam logic [5:0] STEP_READ0 = 6'h04;
	localparam logic [5:0] STEP_LAST = 6'h1d;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCL_QTR_NS = 5000;
	localparam int SCL_QTR_CYC = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// State types
	// ****************************************
	typedef enum logic [2:0] {
		D_IDLE, D_ADDR, D_ADDR_ACK, D_WRITE, D_WRITE_ACK, D_READ, D_READ_ACK
	} dev_state_t;
	typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} host_state_t;

endpackage

// ==== touch_i2c_if.sv ====
// Open-drain serial link plus interrupt line between host and touch module.
// Assumes each party drives only its own enables; the wire levels are resolved here.
`timescale 1ns/100ps
interface touch_i2c_if;
	// Host drives clock and data, module drives data and interrupt
	logic scl_host_out;
	logic scl_host_oe;
	logic sda_host_out;
	logic sda_host_oe;
	logic sda_dev_out;
	logic sda_dev_oe;
	logic int_n;
	logic scl;
	logic sda;

	// Pulled-up lines: low when any enabled driver drives low
	assign scl = ~(scl_host_oe & ~scl_host_out);
	assign sda = ~((sda_host_oe & ~sda_host_out) | (sda_dev_oe & ~sda_dev_out));

	modport host (
		output scl_host_out, scl_host_oe, sda_host_out, sda_host_oe,
		input scl, sda, int_n
	);
	modport device (
		output sda_dev_out, sda_dev_oe, int_n,
		input scl, sda
	);
endinterface

// ==== i2c_line_watch.sv ====
// Edge and bus condition detector for the serial clock and data lines.
// Assumes the lines are already synchronous to the clock.
`timescale 1ns/100ps
module i2c_line_watch (
	// Clock, reset and enable
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	// Lines
	input wire logic scl_in,
	input wire logic sda_in,
	// Events
	output logic scl_rise_out,
	output logic scl_fall_out,
	output logic start_out,
	output logic stop_out
);
	logic scl_q;
	logic sda_q;

	// Previous line levels, idle high
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
		end else if (ce_in) begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	// Data changing while clock stays high marks start or stop
	assign scl_rise_out = ~scl_q & scl_in;
	assign scl_fall_out = scl_q & ~scl_in;
	assign start_out = scl_q & scl_in & sda_q & ~sda_in;
	assign stop_out = scl_q & scl_in & ~sda_q & sda_in;
endmodule

// ==== touch_report_host.sv ====
// Host end of the touch report link: on interrupt it writes the start command,
// restarts, reads the 26-byte report and checks its XOR checksum.
// Assumes the module never stretches the clock; link runs at a quarter-based rate.
`timescale 1ns/100ps
module touch_report_host #(
	parameter logic [7:0] START_CMD = touch_pkg::START_CMD_DEF,
	parameter int QTR_CYC = touch_pkg::SCL_QTR_CYC
) (
	// Clock, reset and enable
	input wire logic MCLK_IN,
	input wire logic RESETN_IN,
	input wire logic CE_IN,
	// Serial link
	touch_i2c_if.host BUS,
	// Control
	input wire logic ENABLE_IN,
	input wire logic [3:0] ADDR_LOW_IN,
	// Received report
	output logic [7:0] RX_DATA_OUT,
	output logic [4:0] RX_INDEX_OUT,
	output logic RX_VALID_OUT,
	output logic DONE_OUT,
	output logic CSUM_OK_OUT,
	output logic NACK_OUT,
	output logic BUSY_OUT
);
	touch_pkg::host_state_t state_q;
	logic [15:0] qcnt_q;
	logic [1:0] phase_q;
	logic [3:0] bitn_q;
	logic [5:0] step_q;
	logic [7:0] tx_q;
	logic [7:0] rx_q;
	logic [7:0] xor_q;
	logic ack_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic tick;
	logic rd;
	logic [7:0] addr_w;
	logic [7:0] addr_r;

	assign tick = qcnt_q == 16'(QTR_CYC - 1);
	assign rd = step_q >= touch_pkg::STEP_READ0;
	assign addr_w = {touch_pkg::ADDR_HI, ADDR_LOW_IN, touch_pkg::RW_WRITE};
	assign addr_r = {touch_pkg::ADDR_HI, ADDR_LOW_IN, touch_pkg::RW_READ};

	// ****************************************
	// Quarter-bit timer
	// ****************************************
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			qcnt_q <= 16'h0000;
		end else if (CE_IN) begin
			qcnt_q <= (tick || state_q == touch_pkg::H_IDLE) ? 16'h0000 : qcnt_q + 16'h0001;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge MCLK_IN) begin
		if (!RESETN_IN) begin
			state_q <= touch_pkg::H_IDLE;
			phase_q <= 2'h0;
			bitn_q <= 4'h0;
			step_q <= touch_pkg::STEP_ADDR_W;
			tx_q <= 8'h00;
			rx_q <= 8'h00;
			xor_q <= 8'h00;
			ack_q <= 1'h0;
			scl_oe_q <= 1'h0;
			sda_oe_q <= 1'h0;
			RX_DATA_OUT <= 8'h00;
			RX_INDEX_OUT <= 5'h00;
			RX_VALID_OUT <= 1'h0;
			DONE_OUT <= 1'h0;
			CSUM_OK_OUT <= 1'h0;
			NACK_OUT <= 1'h0;
			BUSY_OUT <= 1'h0;
		end else if (CE_IN) begin
			RX_VALID_OUT <= 1'h0;
			DONE_OUT <= 1'h0;
			NACK_OUT <= 1'h0;
			case (state_q)
				touch_pkg::H_IDLE: begin
					if (ENABLE_IN && !BUS.int_n) begin
						state_q <= touch_pkg::H_START;
						step_q <= touch_pkg::STEP_ADDR_W;
						phase_q <= 2'h0;
						xor_q <= 8'h00;
						BUSY_OUT <= 1'h1;
					end
				end
				touch_pkg::H_START: if (tick) begin
					phase_q <= phase_q + 2'h1;
					case (phase_q)
						2'h0: sda_oe_q <= 1'h0;
						2'h1: scl_oe_q <= 1'h0;
						2'h2: sda_oe_q <= 1'h1; // Data falls with clock high
						default: begin
							scl_oe_q <= 1'h1;
							bitn_q <= 4'h0;
							state_q <= touch_pkg::H_BYTE;
							if (step_q == touch_pkg::STEP_RESTART) begin
								step_q <= touch_pkg::STEP_ADDR_R;
								tx_q <= addr_r;
							end else begin
								tx_q <= addr_w;
							end
						end
					endcase
				end
				touch_pkg::H_BYTE: if (tick) begin
					phase_q <= phase_q + 2'h1;
					case (phase_q)
						2'h0: begin
							if (bitn_q != touch_pkg::ACK_SLOT) begin
								sda_oe_q <= rd ? 1'h0 : ~tx_q[7];
							end else begin
								sda_oe_q <= rd && step_q != touch_pkg::STEP_LAST;
							end
						end
						2'h1: scl_oe_q <= 1'h0;
						2'h2: begin
							if (bitn_q != touch_pkg::ACK_SLOT) begin
								rx_q <= {rx_q[6:0], BUS.sda};
								tx_q <= {tx_q[6:0], 1'h0};
							end else begin
								ack_q <= BUS.sda;
							end
						end
						default: begin
							scl_oe_q <= 1'h1;
							bitn_q <= bitn_q + 4'h1;
							if (bitn_q == touch_pkg::ACK_SLOT) begin
								bitn_q <= 4'h0;
								if (!rd && ack_q != touch_pkg::ACK_LOW) begin
									NACK_OUT <= 1'h1;
									state_q <= touch_pkg::H_STOP;
								end else if (step_q == touch_pkg::STEP_ADDR_W) begin
									step_q <= touch_pkg::STEP_CMD;
									tx_q <= START_CMD;
								end else if (step_q == touch_pkg::STEP_CMD) begin
									step_q <= touch_pkg::STEP_RESTART;
									state_q <= touch_pkg::H_START;
								end else if (step_q == touch_pkg::STEP_ADDR_R) begin
									step_q <= touch_pkg::STEP_READ0;
								end else begin
									RX_DATA_OUT <= rx_q;
									RX_INDEX_OUT <= 5'(step_q - touch_pkg::STEP_READ0);
									RX_VALID_OUT <= 1'h1;
									xor_q <= xor_q ^ rx_q;
									step_q <= step_q + 6'h01;
									if (step_q == touch_pkg::STEP_LAST) begin
										CSUM_OK_OUT <= xor_q == rx_q;
										state_q <= touch_pkg::H_STOP;
									end
								end
							end
						end
					endcase
				end
				touch_pkg::H_STOP: if (tick) begin
					phase_q <= phase_q + 2'h1;
					case (phase_q)
						2'h0: sda_oe_q <= 1'h1;
						2'h1: scl_oe_q <= 1'h0;
						2'h2: sda_oe_q <= 1'h0;
						default: begin
							DONE_OUT <= 1'h1;
							BUSY_OUT <= 1'h0;
							state_q <= touch_pkg::H_IDLE;
						end
					endcase
				end
				default: state_q <= touch_pkg::H_IDLE;
			endcase
		end
	end

	// Link drivers pull low only
	assign BUS.scl_host_out = touch_pkg::OD_LOW;
	assign BUS.sda_host_out = touch_pkg::OD_LOW;
	assign BUS.scl_host_oe = scl_oe_q;
	assign BUS.sda_host_oe = sda_oe_q;
endmodule

// ==== touch_report_chk.sv ====
// Concurrent checks on the resolved serial link and interrupt line.
// Assumes one clock domain and a host running with a quarter of four cycles.
`timescale 1ns/100ps
module touch_report_chk (
	// Clock and reset
	input wire logic MCLK_IN,
	input wire logic RESETN_IN,
	// Resolved link levels and drive enables
	input wire logic scl,
	input wire logic sda,
	input wire logic int_n,
	input wire logic sda_dev_oe
);
	// ****************************************
	// Link properties
	// ****************************************
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!RESETN_IN);

	// Data falling while the clock stays high
	sequence start_seen;
		scl && $past(scl) && $fell(sda);
	endsequence

	a_scl_high_len: assert property ($rose(scl) |=> scl [*6])
		else $error("serial clock high phase too short");
	a_scl_low_len: assert property ($fell(scl) |=> !scl [*3])
		else $error("serial clock low phase too short");
	a_start_dev_free: assert property (start_seen |-> !sda_dev_oe)
		else $error("module pulls data at a start");
	a_stop_scl_idle: assert property (scl && $past(scl) && $rose(sda) |=> scl [*3])
		else $error("clock dropped right after a stop");
	a_dev_change_low: assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("module data moved while clock high");
	a_ack_stands: assert property ($rose(sda_dev_oe) |=> sda_dev_oe [*3])
		else $error("module low level released too soon");
	a_int_low_hold: assert property ($fell(int_n) |=> !int_n [*4])
		else $error("interrupt pulse too short");
	a_int_rise_ack: assert property ($rose(int_n) |-> !sda)
		else $error("interrupt released outside an acknowledge");

	// Main scenarios reached
	c_int_seen: cover property ($fell(int_n));
	c_start_seen: cover property (start_seen);
	c_dev_drive: cover property ($rose(sda_dev_oe));
endmodule

// ==== tb_touch_packet_i2c_reader.sv ====
// Self-checking bench: host and touch module face each other over the link.
// Assumes a 10 MHz clock; the host quarter is shortened to four cycles.
`timescale 1ns/100ps
module tb_touch_packet_i2c_reader;
	localparam logic [7:0] CMD = 8'h5c;
	logic mclk_in, resetn_in, enable_in, report_valid_in, fetched, scl_p, sda_p;
	logic in_pkt = 1'b0;
	logic rw_exp = 1'b0;
	logic rx_valid, done, csum_ok, nack, busy;
	logic [3:0] addr_low_in, point_count_in;
	logic [7:0] addr_cfg_in, rx_data;
	logic [7:0] sh = 8'h00;
	logic [4:0] rx_index;
	logic [8:0] nbits = 9'h000;
	logic [59:0] x_in, y_in;
	logic [7:0] exp_q[$];
	logic [4:0] idx_q[$];
	int errors, cmp_count, fetch_n;

	// ****************************************
	// Design and checker
	// ****************************************
	touch_i2c_if touch_i2c_if_i ();
	touch_report_device #(.START_CMD(CMD)) touch_report_device_i (.MCLK_IN(mclk_in),
		.RESETN_IN(resetn_in), .CE_IN(1'b1), .BUS(touch_i2c_if_i.device),
		.ADDR_CFG_IN(addr_cfg_in), .REPORT_VALID_IN(report_valid_in),
		.POINT_COUNT_IN(point_count_in), .X_IN(x_in), .Y_IN(y_in), .FETCHED_OUT(fetched));
	touch_report_host #(.START_CMD(CMD), .QTR_CYC(4)) touch_report_host_i (.MCLK_IN(mclk_in),
		.RESETN_IN(resetn_in), .CE_IN(1'b1), .BUS(touch_i2c_if_i.host), .ENABLE_IN(enable_in),
		.ADDR_LOW_IN(addr_low_in), .RX_DATA_OUT(rx_data), .RX_INDEX_OUT(rx_index),
		.RX_VALID_OUT(rx_valid), .DONE_OUT(done), .CSUM_OK_OUT(csum_ok), .NACK_OUT(nack),
		.BUSY_OUT(busy));
	touch_report_chk touch_report_chk_i (.MCLK_IN(mclk_in), .RESETN_IN(resetn_in),
		.scl(touch_i2c_if_i.scl), .sda(touch_i2c_if_i.sda), .int_n(touch_i2c_if_i.int_n),
		.sda_dev_oe(touch_i2c_if_i.sda_dev_oe));

	// ****************************************
	// Shared tasks
	// ****************************************
	// Counted comparison
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Random report snapshot; the expected bytes are queued when asked
	task automatic send_report(input logic [3:0] cnt, input bit push);
		logic [7:0] b[26];
		@(negedge mclk_in);
		point_count_in = cnt;
		for (int p = 0; p < 5; p++) begin
			x_in[12*p+:12] = 12'($urandom);
			y_in[12*p+:12] = 12'($urandom);
		end
		if (cnt == 4'h5) begin
			x_in[11:0] = 12'hfff;
		end
		b[0] = 8'haa;
		b[1] = 8'haa;
		b[2] = 8'h1a;
		b[3] = {4'h0, cnt};
		b[4] = 8'h00;
		for (int p = 0; p < 5; p++) begin
			b[5+4*p] = {4'h0, x_in[12*p+8+:4]};
			b[6+4*p] = x_in[12*p+:8];
			b[7+4*p] = {4'h0, y_in[12*p+8+:4]};
			b[8+4*p] = y_in[12*p+:8];
		end
		b[25] = 8'h00;
		for (int i = 0; i < 25; i++) begin
			b[25] = b[25] ^ b[i];
		end
		for (int i = 0; push && i < 26; i++) begin
			exp_q.push_back(b[i]);
			idx_q.push_back(5'(i));
		end
		report_valid_in = 1'b1;
		@(negedge mclk_in);
		report_valid_in = 1'b0;
	endtask

	// Bounded wait: 0 for done, 1 for a refused byte, 2 for idle
	task automatic wait_sig(input int sel);
		int n;
		n = 0;
		while (!((sel == 0 && done === 1'b1) || (sel == 1 && nack === 1'b1)
			|| (sel == 2 && busy === 1'b0)) && n < 20000) begin
			@(negedge mclk_in);
			n++;
		end
		if (n >= 20000) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, sel, 1);
		end
	endtask

	task automatic results();
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ****************************************
	// Monitors
	// ****************************************
	// Each received byte is matched against the oldest queued note
	always @(negedge mclk_in) begin
		if (fetched === 1'b1) begin
			fetch_n++;
		end
		if (rx_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(rx_data, 8'hxx);
			end else begin
				check(rx_data, exp_q.pop_front());
				check({3'h0, rx_index}, {3'h0, idx_q.pop_front()});
			end
		end
	end

	// Address byte on the wire; a start inside a packet must ask to read
	always @(negedge mclk_in) begin
		scl_p <= touch_i2c_if_i.scl;
		sda_p <= touch_i2c_if_i.sda;
		if (touch_i2c_if_i.scl && scl_p && sda_p && !touch_i2c_if_i.sda) begin
			nbits <= 9'h000;
			rw_exp <= in_pkt;
			in_pkt <= 1'b1;
		end else if (touch_i2c_if_i.scl && scl_p && !sda_p && touch_i2c_if_i.sda) begin
			in_pkt <= 1'b0;
		end else if (touch_i2c_if_i.scl && !scl_p) begin
			sh <= {sh[6:0], touch_i2c_if_i.sda};
			nbits <= nbits + 9'h001;
			if (nbits == 9'h007) begin
				check({sh[6:0], touch_i2c_if_i.sda}, {3'h3, addr_low_in, rw_exp});
			end
		end
	end

	// ****************************************
	// Clock, stimulus and watchdog
	// ****************************************
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	initial begin
		repeat (60000) @(posedge mclk_in);
		errors++;
		results();
	end

	initial begin
		errors = 0;
		cmp_count = 0;
		fetch_n = 0;
		resetn_in = 1'b0;
		enable_in = 1'b0;
		report_valid_in = 1'b0;
		point_count_in = 4'h0;
		addr_low_in = 4'h9;
		addr_cfg_in = 8'h95;
		x_in = '0;
		y_in = '0;
		void'($urandom(32'h0974));
		repeat (6) @(negedge mclk_in);
		resetn_in = 1'b1;
		@(negedge mclk_in);
		check({7'h0, touch_i2c_if_i.int_n}, 8'h01);
		enable_in = 1'b1;
		// Fetches at address nibbles 0, f, 9 with counts 0, 5 and random
		for (int k = 0; k < 3; k++) begin
			addr_low_in = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'h9;
			addr_cfg_in = {addr_low_in, 4'(~addr_low_in)};
			send_report((k == 0) ? 4'h0 : (k == 1) ? 4'h5 : 4'($urandom_range(1, 4)), 1'b1);
			wait_sig(0);
			check({7'h0, csum_ok}, 8'h01);
		end
		// Wrong address is refused; a newer unread report replaces the older one
		addr_low_in = 4'h6;
		send_report(4'h2, 1'b0);
		wait_sig(1);
		enable_in = 1'b0;
		wait_sig(2);
		send_report(4'h3, 1'b1);
		check(8'(exp_q.size()), 8'h1a);
		addr_low_in = 4'h9;
		enable_in = 1'b1;
		// A report offered while the packet is being read out is dropped
		repeat (1500) @(negedge mclk_in);
		send_report(4'h7, 1'b0);
		wait_sig(0);
		check({7'h0, csum_ok}, 8'h01);
		check({7'h0, touch_i2c_if_i.int_n}, 8'h01);
		check(8'(fetch_n), 8'h04);
		check(8'(exp_q.size()), 8'h00);
		results();
	end
endmodule
